// file: hdl/pmd_pkg.sv
package pmd_pkg;
    // geometry
    localparam int ROW_BITS      = 9;
    localparam int COL_BITS      = 9;
    localparam int ADDR_BITS     = 18;
    localparam int DATA_BITS     = 16;
    localparam int ROW_COUNT     = 512;
    // clock and timing figures
    localparam int CLK_PERIOD_PS = 4000;
    localparam int CYC_TIME_NS   = 60;     // full random cycle, fastest grade
    localparam int PAGE_TIME_NS  = 12;     // page column cycle, fastest grade
    localparam int ACCESS_NS     = 35;     // row strobe to valid data
    localparam int ROW_ACT_NS    = 35;     // row active minimum
    localparam int PRECHG_NS     = 25;     // precharge after row strobe rises
    localparam int REFI_NS       = 8000000;
    localparam int PWRUP_US      = 200;
    localparam int INIT_CYCLES   = 8;
    // least times round up except the power-up pause, longest times round down
    localparam int ACCESS_CYC  = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int ROW_ACT_CYC = (ROW_ACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PRECHG_CYC  = (PRECHG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_CYC     = (CYC_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PAGE_HALF   = ((PAGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1) / 2;
    localparam int REFI_CYC    = (REFI_NS / ROW_COUNT) * 1000 / CLK_PERIOD_PS;
    localparam int PWRUP_CYC   = PWRUP_US * 1000000 / CLK_PERIOD_PS;
    localparam int CNT_W       = 16;

    typedef enum logic [1:0] {
        PMD_OP_READ,
        PMD_OP_WRITE,
        PMD_OP_RMW
    } pmd_op_t;

    // user request
    typedef struct packed {
        pmd_op_t                op;
        logic [ADDR_BITS-1:0]   addr;
        logic [DATA_BITS-1:0]   wdata;
        logic [1:0]             lane_en;   // bit0 lower byte, bit1 upper byte
    } pmd_req_t;

    // dram pin bundle, strobes active low
    typedef struct packed {
        logic                   row_strobe_n;
        logic                   lower_lane_col_strobe_n;
        logic                   upper_lane_col_strobe_n;
        logic                   write_en_n;
        logic                   out_en_n;
        logic [ROW_BITS-1:0]    mux_addr_bus;
        logic [DATA_BITS-1:0]   data_out;
        logic [1:0]             data_oe;
    } pmd_pins_t;
endpackage

// file: hdl/pmd_ctrl.sv
`timescale 1ns/10ps
module pmd_ctrl #(
    parameter int PWRUP_CYCLES = pmd_pkg::PWRUP_CYC,
    parameter int REFI_CYCLES  = pmd_pkg::REFI_CYC
) (
    input  wire logic                               mclk,
    input  wire logic                               sys_rst,
    input  wire logic                               clk_en,
    input  wire logic                               req_valid,
    output logic                                    req_ready,
    input  wire pmd_pkg::pmd_req_t                  req,
    input  wire logic                               page_hit_en,
    output logic                                    rsp_valid,
    output logic [pmd_pkg::DATA_BITS-1:0]           rsp_rdata,
    output logic                                    init_done,
    output logic                                    row_strobe_n,
    output logic                                    lower_lane_col_strobe_n,
    output logic                                    upper_lane_col_strobe_n,
    output logic                                    write_en_n,
    output logic                                    out_en_n,
    output logic [pmd_pkg::ROW_BITS-1:0]            mux_addr_bus,
    output logic [pmd_pkg::DATA_BITS-1:0]           data_pins_o,
    output logic [1:0]                              data_pins_oe,
    input  wire logic [pmd_pkg::DATA_BITS-1:0]      data_pins_i
);
    initial begin
        if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= 2**24 || REFI_CYCLES < 64 || REFI_CYCLES >= 2**pmd_pkg::CNT_W)
            $error("pmd_ctrl: timing parameter out of range");
    end

    typedef enum logic [3:0] {
        ST_PWRUP, ST_INIT, ST_IDLE, ST_ROW, ST_COL, ST_WAIT, ST_RMW_WR, ST_PAGE_PRE, ST_REF_CAS,
        ST_REF_RAS, ST_PRECHG
    } pmd_state_t;

    typedef struct packed {
        pmd_state_t                     state;
        logic [23:0]                    pwr_cnt;
        logic [3:0]                     init_cnt;
        logic [pmd_pkg::CNT_W-1:0]      refi_cnt;
        logic                           ref_pend;
        logic [7:0]                     tmr;
        logic [7:0]                     ras_age;
        logic                           row_open;
        logic [pmd_pkg::ROW_BITS-1:0]   open_row;
        pmd_pkg::pmd_req_t              cur;
        pmd_pkg::pmd_pins_t             pins;
        logic                           rsp_valid;
        logic [pmd_pkg::DATA_BITS-1:0]  rdata;
        logic                           init_done;
    } pmd_st_t;

    pmd_st_t st_reg;
    pmd_st_t st_next;
    logic [pmd_pkg::DATA_BITS-1:0] din_meta_reg;
    logic [pmd_pkg::DATA_BITS-1:0] din_sync_reg;

    function automatic logic [pmd_pkg::ROW_BITS-1:0] row_of(input logic [pmd_pkg::ADDR_BITS-1:0] a);
        row_of = a[pmd_pkg::ADDR_BITS-1:pmd_pkg::COL_BITS];
    endfunction

    function automatic logic [pmd_pkg::COL_BITS-1:0] col_of(input logic [pmd_pkg::ADDR_BITS-1:0] a);
        col_of = a[pmd_pkg::COL_BITS-1:0];
    endfunction

    // merge sampled lanes, only strobed lanes carry data
    function automatic logic [pmd_pkg::DATA_BITS-1:0] lane_merge(input logic [pmd_pkg::DATA_BITS-1:0] old_d,
                                                               input logic [pmd_pkg::DATA_BITS-1:0] new_d,
                                                               input logic [1:0] en);
        lane_merge = old_d;
        if (en[0])
            lane_merge[7:0] = new_d[7:0];
        if (en[1])
            lane_merge[15:8] = new_d[15:8];
    endfunction

    localparam logic [7:0] ACC_C  = 8'(pmd_pkg::ACCESS_CYC);
    localparam logic [7:0] RAS_C  = 8'(pmd_pkg::ROW_ACT_CYC);
    localparam logic [7:0] PRE_C  = 8'(pmd_pkg::PRECHG_CYC);
    localparam logic [7:0] CYC_C  = 8'(pmd_pkg::CYC_CYC);
    localparam logic [7:0] PAGE_C = 8'(pmd_pkg::PAGE_HALF);

    // input pins pass two flops before use
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            din_meta_reg <= 16'h0000;
            din_sync_reg <= 16'h0000;
        end else if (clk_en) begin
            din_meta_reg <= data_pins_i;
            din_sync_reg <= din_meta_reg;
        end
    end

    // a miss or a page being closed costs a precharge first, so it is not taken yet
    assign req_ready = (st_reg.state == ST_IDLE) && !st_reg.ref_pend && st_reg.init_done &&
                       (!st_reg.row_open || (page_hit_en && row_of(req.addr) == st_reg.open_row));

    always_comb begin
        st_next = st_reg;
        st_next.rsp_valid = 1'b0;
        // refresh interval tick, one row per tick keeps 512 rows in 8 ms
        if (st_reg.refi_cnt == pmd_pkg::CNT_W'(REFI_CYCLES - 1)) begin
            st_next.refi_cnt = '0;
            st_next.ref_pend = 1'b1;
        end else begin
            st_next.refi_cnt = st_reg.refi_cnt + 1'b1;
        end
        if (st_reg.tmr != 8'h00)
            st_next.tmr = st_reg.tmr - 1'b1;
        if (!st_reg.pins.row_strobe_n && st_reg.ras_age != 8'hff)
            st_next.ras_age = st_reg.ras_age + 1'b1;
        case (st_reg.state)
            ST_PWRUP: begin
                // pins idle high through the pause
                if (st_reg.pwr_cnt == 24'(PWRUP_CYCLES - 1))
                    st_next.state = ST_INIT;
                else
                    st_next.pwr_cnt = st_reg.pwr_cnt + 1'b1;
            end
            ST_INIT: begin
                // eight column-first refreshes count as init cycles
                if (st_reg.init_cnt == 4'(pmd_pkg::INIT_CYCLES)) begin
                    st_next.init_done = 1'b1;
                    st_next.state = ST_IDLE;
                end else if (st_reg.tmr == 8'h00) begin
                    st_next.init_cnt = st_reg.init_cnt + 1'b1;
                    st_next.state = ST_REF_CAS;
                end
            end
            ST_IDLE: begin
                if (st_reg.ref_pend) begin
                    // an open row is closed first and the refresh stays pending; a tick now wins
                    if (!st_reg.row_open)
                        st_next.ref_pend = (st_reg.refi_cnt == pmd_pkg::CNT_W'(REFI_CYCLES - 1));
                    st_next.state = st_reg.row_open ? ST_PAGE_PRE : ST_REF_CAS;
                end else if (req_valid && req_ready) begin
                    st_next.cur = req;
                    if (!st_reg.row_open) begin
                        st_next.pins.mux_addr_bus = row_of(req.addr);
                        st_next.state = ST_ROW;
                        st_next.tmr = 8'h01;
                    end else begin
                        st_next.pins.mux_addr_bus = col_of(req.addr);
                        st_next.state = ST_COL;
                        st_next.tmr = 8'h01;
                    end
                end else if (st_reg.row_open && (req_valid || !page_hit_en)) begin
                    st_next.state = ST_PAGE_PRE;
                end
            end
            ST_ROW: begin
                // address setup two cycles, then row strobe falls
                if (st_reg.pins.row_strobe_n && st_reg.tmr == 8'h00) begin
                    st_next.pins.row_strobe_n = 1'b0;
                    st_next.ras_age = 8'h00;
                    st_next.row_open = 1'b1;
                    st_next.open_row = row_of(st_reg.cur.addr);
                    st_next.tmr = 8'h02;
                end else if (!st_reg.pins.row_strobe_n && st_reg.tmr == 8'h00) begin
                    st_next.pins.mux_addr_bus = col_of(st_reg.cur.addr);
                    st_next.state = ST_COL;
                    st_next.tmr = 8'h01;
                end
            end
            ST_COL: begin
                if (st_reg.tmr == 8'h00) begin
                    // write enable set in the same cycle as the column strobes
                    st_next.pins.write_en_n = (st_reg.cur.op != pmd_pkg::PMD_OP_WRITE);
                    st_next.pins.out_en_n = (st_reg.cur.op == pmd_pkg::PMD_OP_WRITE);
                    st_next.pins.lower_lane_col_strobe_n = !st_reg.cur.lane_en[0];
                    st_next.pins.upper_lane_col_strobe_n = !st_reg.cur.lane_en[1];
                    if (st_reg.cur.op == pmd_pkg::PMD_OP_WRITE) begin
                        st_next.pins.data_out = st_reg.cur.wdata;
                        st_next.pins.data_oe = st_reg.cur.lane_en;
                    end
                    // covers row access time plus the sync delay
                    st_next.tmr = (ACC_C > PAGE_C) ? ACC_C : PAGE_C;
                    st_next.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (st_reg.tmr == 8'h00 && st_reg.ras_age >= RAS_C) begin
                    if (st_reg.cur.op != pmd_pkg::PMD_OP_WRITE)
                        st_next.rdata = lane_merge(16'h0000, din_sync_reg, st_reg.cur.lane_en);
                    if (st_reg.cur.op == pmd_pkg::PMD_OP_RMW) begin
                        // release output enable before driving the bus
                        st_next.pins.out_en_n = 1'b1;
                        st_next.tmr = 8'h01;
                        st_next.state = ST_RMW_WR;
                    end else begin
                        st_next.rsp_valid = 1'b1;
                        st_next.pins.lower_lane_col_strobe_n = 1'b1;
                        st_next.pins.upper_lane_col_strobe_n = 1'b1;
                        st_next.pins.data_oe = 2'b00;
                        st_next.pins.write_en_n = 1'b1;
                        st_next.pins.out_en_n = 1'b1;
                        st_next.tmr = PAGE_C;
                        st_next.state = ST_PRECHG;
                    end
                end
            end
            ST_RMW_WR: begin
                if (st_reg.tmr == 8'h00 && st_reg.pins.write_en_n) begin
                    st_next.pins.data_out = lane_merge(st_reg.rdata, st_reg.cur.wdata, st_reg.cur.lane_en);
                    st_next.pins.data_oe = st_reg.cur.lane_en;
                    st_next.pins.write_en_n = 1'b0;
                    st_next.tmr = PAGE_C;
                end else if (st_reg.tmr == 8'h00) begin
                    st_next.rsp_valid = 1'b1;
                    st_next.pins.lower_lane_col_strobe_n = 1'b1;
                    st_next.pins.upper_lane_col_strobe_n = 1'b1;
                    st_next.pins.data_oe = 2'b00;
                    st_next.pins.write_en_n = 1'b1;
                    st_next.tmr = PAGE_C;
                    st_next.state = ST_PRECHG;
                end
            end
            ST_PRECHG: begin
                // column precharge after an access, row precharge after a close or a refresh
                if (st_reg.tmr == 8'h00)
                    st_next.state = ST_IDLE;
            end
            ST_PAGE_PRE: begin
                // close row only after row active minimum
                if (st_reg.ras_age >= RAS_C && st_reg.tmr == 8'h00) begin
                    st_next.pins.row_strobe_n = 1'b1;
                    st_next.row_open = 1'b0;
                    st_next.tmr = (CYC_C > RAS_C + PRE_C) ? CYC_C - RAS_C : PRE_C;
                    st_next.state = ST_PRECHG;
                end
            end
            ST_REF_CAS: begin
                // both column strobes low first, write high, address ignored
                if (st_reg.tmr == 8'h00 && st_reg.pins.lower_lane_col_strobe_n) begin
                    st_next.pins.lower_lane_col_strobe_n = 1'b0;
                    st_next.pins.upper_lane_col_strobe_n = 1'b0;
                    st_next.tmr = 8'h02;
                end else if (st_reg.tmr == 8'h00) begin
                    st_next.pins.row_strobe_n = 1'b0;
                    st_next.ras_age = 8'h00;
                    st_next.tmr = RAS_C;
                    st_next.state = ST_REF_RAS;
                end
            end
            ST_REF_RAS: begin
                if (st_reg.tmr == 8'h00) begin
                    st_next.pins.row_strobe_n = 1'b1;
                    st_next.pins.lower_lane_col_strobe_n = 1'b1;
                    st_next.pins.upper_lane_col_strobe_n = 1'b1;
                    st_next.tmr = PRE_C;
                    st_next.state = st_reg.init_done ? ST_PRECHG : ST_INIT;
                end
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
    end

    // single state register, clock enable freezes all of it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.state <= ST_PWRUP;
            st_reg.pins.row_strobe_n <= 1'b1;
            st_reg.pins.lower_lane_col_strobe_n <= 1'b1;
            st_reg.pins.upper_lane_col_strobe_n <= 1'b1;
            st_reg.pins.write_en_n <= 1'b1;
            st_reg.pins.out_en_n <= 1'b1;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign rsp_valid               = st_reg.rsp_valid;
    assign rsp_rdata               = st_reg.rdata;
    assign init_done               = st_reg.init_done;
    assign row_strobe_n            = st_reg.pins.row_strobe_n;
    assign lower_lane_col_strobe_n = st_reg.pins.lower_lane_col_strobe_n;
    assign upper_lane_col_strobe_n = st_reg.pins.upper_lane_col_strobe_n;
    assign write_en_n              = st_reg.pins.write_en_n;
    assign out_en_n                = st_reg.pins.out_en_n;
    assign mux_addr_bus            = st_reg.pins.mux_addr_bus;
    assign data_pins_o             = st_reg.pins.data_out;
    assign data_pins_oe            = st_reg.pins.data_oe;
endmodule

// file: testbench/pmd_ctrl_asserts.sv
`timescale 1ns/10ps
module pmd_chk #(
    parameter int REFI_CYCLES = 200
) (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       clk_en,
    input wire logic       req_ready,
    input wire logic       rsp_valid,
    input wire logic       init_done,
    input wire logic       row_strobe_n,
    input wire logic       lower_lane_col_strobe_n,
    input wire logic       upper_lane_col_strobe_n,
    input wire logic       write_en_n,
    input wire logic       out_en_n,
    input wire logic [8:0] mux_addr_bus,
    input wire logic [1:0] data_pins_oe
);
    wire         lo_n = lower_lane_col_strobe_n;
    wire         up_n = upper_lane_col_strobe_n;
    logic [15:0] gap_reg;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // cycles since the last column-first refresh; accesses do not restart it
    always_ff @(posedge mclk) begin
        if (sys_rst || !init_done || ($fell(row_strobe_n) && !(lo_n && up_n))) begin
            gap_reg <= 16'h0000;
        end else if (clk_en) begin
            gap_reg <= gap_reg + 16'h0001;
        end
    end

    property p_rst_idle;
        $fell(sys_rst) |-> row_strobe_n && lo_n && up_n && data_pins_oe == 2'b00 && !rsp_valid && !init_done;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
    property p_init_gate;
        !init_done |-> !req_ready;
    endproperty
    a_init_gate: assert property (p_init_gate) else $error("request taken before init");
    property p_row_setup;
        $fell(row_strobe_n) && lo_n && up_n |-> $stable(mux_addr_bus);
    endproperty
    a_row_setup: assert property (p_row_setup) else $error("row address moved at strobe");
    property p_wr_lane;
        !row_strobe_n && !write_en_n && ($fell(lo_n) || $fell(up_n)) |-> data_pins_oe == ~{up_n, lo_n};
    endproperty
    a_wr_lane: assert property (p_wr_lane) else $error("write lanes differ from strobes");
    property p_dir;
        !out_en_n |-> write_en_n && data_pins_oe == 2'b00;
    endproperty
    a_dir: assert property (p_dir) else $error("drive while device may drive");
    property p_cbr;
        $fell(row_strobe_n) && !(lo_n && up_n) |-> (data_pins_oe == 2'b00) [*4];
    endproperty
    a_cbr: assert property (p_cbr) else $error("data driven in refresh");
    property p_ras_min;
        $fell(row_strobe_n) |=> !row_strobe_n [*8];
    endproperty
    a_ras_min: assert property (p_ras_min) else $error("row active too short");
    property p_precharge;
        $rose(row_strobe_n) |=> row_strobe_n [*6];
    endproperty
    a_precharge: assert property (p_precharge) else $error("precharge too short");
    property p_refi;
        init_done |-> gap_reg <= REFI_CYCLES + 100;
    endproperty
    a_refi: assert property (p_refi) else $error("refresh overdue");

    c_word_wr: cover property (!write_en_n && data_pins_oe == 2'b11);
    c_rmw: cover property (!out_en_n ##[1:8] !write_en_n);
    c_cbr: cover property ($fell(row_strobe_n) && !lo_n);
endmodule

bind pmd_ctrl pmd_chk #(.REFI_CYCLES(REFI_CYCLES)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .init_done(init_done), .row_strobe_n(row_strobe_n), .lower_lane_col_strobe_n(lower_lane_col_strobe_n),
    .upper_lane_col_strobe_n(upper_lane_col_strobe_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
    .mux_addr_bus(mux_addr_bus), .data_pins_oe(data_pins_oe));

// file: testbench/pmd_dram_model.sv
`timescale 1ns/10ps
module pmd_dram_model (
    input  wire logic        mclk,
    input  wire logic        row_strobe_n,
    input  wire logic        lower_lane_col_strobe_n,
    input  wire logic        upper_lane_col_strobe_n,
    input  wire logic        write_en_n,
    input  wire logic        out_en_n,
    input  wire logic [8:0]  mux_addr_bus,
    input  wire logic [15:0] data_pins,
    output logic      [15:0] dev_dout,
    output logic      [1:0]  dev_oe
);
    logic [15:0] mem [logic [17:0]]; // storage never decays here
    logic [8:0]  row_reg = 9'h000, col_reg = 9'h000, rfc_reg = 9'h000;
    logic [1:0]  cas_q = 2'b11;
    logic        ras_q = 1'b1, we_q = 1'b1, cbr_reg = 1'b0;
    int          n_cbr = 0;
    wire  [1:0]  cas = {upper_lane_col_strobe_n, lower_lane_col_strobe_n};

    // a lane drives only under its own strobe in a read, never in refresh
    always_comb begin
        for (int l = 0; l < 2; l++) begin
            dev_oe[l] = !row_strobe_n && !cas[l] && write_en_n && !out_en_n && !cbr_reg;
        end
    end

    // controller pins are registered, so sampling on mclk sees settled levels
    always @(posedge mclk) begin
        if (ras_q && !row_strobe_n) begin
            cbr_reg = !(&cas);
            if (&cas) begin
                row_reg = mux_addr_bus;
            end else begin
                rfc_reg = rfc_reg + 9'h001;
                n_cbr++;
            end
        end
        if (row_strobe_n) cbr_reg = 1'b0;
        if (!row_strobe_n && !cbr_reg && (&cas_q) && !(&cas)) col_reg = mux_addr_bus;
        for (int l = 0; l < 2; l++) begin
            if (!row_strobe_n && !cbr_reg && !cas[l] && !write_en_n && (cas_q[l] || we_q)) begin
                if (!mem.exists({row_reg, col_reg})) mem[{row_reg, col_reg}] = 16'h0000;
                mem[{row_reg, col_reg}][l*8 +: 8] = data_pins[l*8 +: 8];
            end
        end
        ras_q = row_strobe_n;
        cas_q = cas;
        we_q = write_en_n;
        dev_dout <= mem.exists({row_reg, col_reg}) ? mem[{row_reg, col_reg}] : 16'h0000;
    end
endmodule

// file: testbench/pmd_ctrl_tb_top.sv
`timescale 1ns/10ps
`define PMD_CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module pmd_ctrl_tb_top;
    localparam int REFI = 300;
    logic              mclk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              clk_en = 1'b1;
    logic              req_valid = 1'b0;
    logic              page_hit_en = 1'b0;
    pmd_pkg::pmd_req_t req = '0;
    logic              req_ready, rsp_valid, init_done, row_strobe_n, lo_n, up_n, write_en_n, out_en_n;
    logic [8:0]        mux_addr_bus;
    logic [15:0]       rsp_rdata, data_pins_o, bus, bus_q = 16'h0000, dev_dout, rd;
    logic [1:0]        data_pins_oe, dev_oe;
    int                mismatches = 0, n_checks = 0, n_acc = 0;

    always #2 mclk = ~mclk;
    // a lane nobody drives toggles, so a stale value never reads as good
    always_comb begin
        for (int l = 0; l < 2; l++) begin
            bus[l*8 +: 8] = data_pins_oe[l] ? data_pins_o[l*8 +: 8] : dev_oe[l] ? dev_dout[l*8 +: 8] : ~bus_q[l*8 +: 8];
        end
    end
    always @(posedge mclk) bus_q <= bus;
    // row openings for access, refreshes excluded
    always @(negedge row_strobe_n) if (lo_n && up_n) n_acc++;

    pmd_ctrl #(.PWRUP_CYCLES(100), .REFI_CYCLES(REFI)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .page_hit_en(page_hit_en), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .init_done(init_done), .row_strobe_n(row_strobe_n), .lower_lane_col_strobe_n(lo_n),
        .upper_lane_col_strobe_n(up_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
        .mux_addr_bus(mux_addr_bus), .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe), .data_pins_i(bus));
    pmd_dram_model m (.mclk(mclk), .row_strobe_n(row_strobe_n), .lower_lane_col_strobe_n(lo_n),
        .upper_lane_col_strobe_n(up_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
        .mux_addr_bus(mux_addr_bus), .data_pins(bus), .dev_dout(dev_dout), .dev_oe(dev_oe));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // request held until taken, then wait for the response pulse
    task automatic do_op(input pmd_pkg::pmd_op_t op, input logic [17:0] a, input logic [15:0] d,
                         input logic [1:0] ln);
        int k = 0;
        @(posedge mclk);
        req <= '{op: op, addr: a, wdata: d, lane_en: ln};
        req_valid <= 1'b1;
        do begin @(negedge mclk); k++; end while (req_ready !== 1'b1 && k < 500);
        @(posedge mclk);
        req_valid <= 1'b0;
        k = 0;
        do begin @(negedge mclk); k++; end while (rsp_valid !== 1'b1 && k < 200);
        if (k >= 200) begin mismatches++; $display("[FAIL] %0t no response", $time); end
        rd = rsp_rdata;
    endtask

    task automatic t_init();
        int k = 0;
        `PMD_CHK({row_strobe_n, lo_n, up_n, data_pins_oe, init_done}, 6'b111000)
        sys_rst <= 1'b0;
        @(negedge mclk);
        `PMD_CHK(req_ready, 1'b0)
        while (init_done !== 1'b1 && k < 2000) begin @(negedge mclk); k++; end
        `PMD_CHK(k >= 100, 1'b1)
        `PMD_CHK(m.n_cbr >= 8, 1'b1)
        $display("test init done");
    endtask

    task automatic t_word();
        do_op(pmd_pkg::PMD_OP_WRITE, 18'h3_FFFF, 16'hA5C3, 2'b11);
        do_op(pmd_pkg::PMD_OP_WRITE, 18'h0_0000, 16'h1234, 2'b11);
        `PMD_CHK(m.mem[18'h3_FFFF], 16'hA5C3)
        do_op(pmd_pkg::PMD_OP_READ, 18'h3_FFFF, 16'h0000, 2'b11);
        `PMD_CHK(rd, 16'hA5C3)
        do_op(pmd_pkg::PMD_OP_READ, 18'h0_0000, 16'h0000, 2'b11);
        `PMD_CHK(rd, 16'h1234)
        $display("test word done");
    endtask

    task automatic t_byte();
        do_op(pmd_pkg::PMD_OP_WRITE, 18'h1_2345, 16'h1111, 2'b11);
        do_op(pmd_pkg::PMD_OP_WRITE, 18'h1_2345, 16'hAB99, 2'b10);
        do_op(pmd_pkg::PMD_OP_WRITE, 18'h1_2345, 16'h77CD, 2'b01);
        `PMD_CHK(m.mem[18'h1_2345], 16'hABCD)
        do_op(pmd_pkg::PMD_OP_READ, 18'h1_2345, 16'h0000, 2'b01);
        `PMD_CHK(rd, 16'h00CD)
        do_op(pmd_pkg::PMD_OP_READ, 18'h1_2345, 16'h0000, 2'b10);
        `PMD_CHK(rd, 16'hAB00)
        $display("test byte done");
    endtask

    // second read-write is frozen while its request waits on the previous row's precharge; the pins must hold still
    task automatic t_rmw();
        logic [13:0] snap;
        do_op(pmd_pkg::PMD_OP_RMW, 18'h1_2345, 16'h5A5A, 2'b11);
        `PMD_CHK(rd, 16'hABCD)
        `PMD_CHK(m.mem[18'h1_2345], 16'h5A5A)
        fork
            do_op(pmd_pkg::PMD_OP_RMW, 18'h1_2345, 16'hF00F, 2'b10);
            begin
                repeat (8) @(posedge mclk);
                clk_en <= 1'b0;
                @(negedge mclk);
                snap = {row_strobe_n, lo_n, up_n, write_en_n, out_en_n, mux_addr_bus};
                repeat (6) @(negedge mclk);
                `PMD_CHK({row_strobe_n, lo_n, up_n, write_en_n, out_en_n, mux_addr_bus}, snap)
                @(posedge mclk);
                clk_en <= 1'b1;
            end
        join
        `PMD_CHK(rd, 16'h5A00)
        `PMD_CHK(m.mem[18'h1_2345], 16'hF05A)
        $display("test rmw done");
    endtask

    // start just after a refresh so the open row stays open
    task automatic t_page();
        int k = 0;
        int c0 = m.n_cbr;
        @(posedge mclk);
        page_hit_en <= 1'b1;
        while (m.n_cbr == c0 && k < 2000) begin @(negedge mclk); k++; end
        c0 = n_acc;
        do_op(pmd_pkg::PMD_OP_WRITE, 18'h0_A001, 16'h0F0F, 2'b11);
        do_op(pmd_pkg::PMD_OP_WRITE, 18'h0_A1FF, 16'hF0F0, 2'b11);
        do_op(pmd_pkg::PMD_OP_READ, 18'h0_A001, 16'h0000, 2'b11);
        `PMD_CHK(rd, 16'h0F0F)
        `PMD_CHK(n_acc - c0, 1)
        `PMD_CHK(m.mem[18'h0_A1FF], 16'hF0F0)
        @(posedge mclk);
        page_hit_en <= 1'b0;
        $display("test page done");
    endtask

    task automatic t_refresh();
        int c0 = m.n_cbr;
        repeat (REFI * 3 + 100) @(posedge mclk);
        `PMD_CHK(m.n_cbr - c0 >= 3, 1'b1)
        do_op(pmd_pkg::PMD_OP_READ, 18'h3_FFFF, 16'h0000, 2'b11);
        `PMD_CHK(rd, 16'hA5C3)
        $display("test refresh done");
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        t_init();
        t_word();
        t_byte();
        t_rmw();
        t_page();
        t_refresh();
        give_verdict();
    end

    // run needs a few thousand cycles; this bound cuts a hang short
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        $display("[FAIL] %0t watchdog", $time);
        give_verdict();
    end
endmodule
